// file: rtl/rcst_consts.svh
`ifndef RCST_CONSTS_SVH
`define RCST_CONSTS_SVH
`define RCST_IDX_MCC      16'h0038
`define RCST_IDX_TRIM_HI  16'h0039
`define RCST_IDX_INTEGRITY_CTRL_STATUS    16'h003a
`define RCST_IDX_CKSW     16'h003f
`define RCST_IDX_FT_HI_5V 16'hdee0
`define RCST_IDX_FT_LO_5V 16'hdee1
`define RCST_IDX_FT_HI_3V 16'hdee2
`define RCST_IDX_FT_LO_3V 16'hdee3
`define RCST_RST_MCC      8'h00
`define RCST_RST_TRIM_HI  8'hff
`define RCST_RST_TRIM_LO  2'h0
`define RCST_RST_CKSW     8'h09
`define RCST_MCC_SMS      0
`define RCST_MCC_MCO      1
`define RCST_INTEGRITY_CTRL_STATUS_TLO_HI 6
`define RCST_INTEGRITY_CTRL_STATUS_TLO_LO 5
`define RCST_CKSW_SEL     0
`define RCST_CKSW_MRC_RDY 2
`define RCST_CKSW_LP_RDY  3
`define RCST_LP_READY_CYC 4'h3
`define RCST_MRC_WAIT_CYC 4'h8
`define RCST_MRC_FLAG_CYC 4'h2
`define RCST_SLOW_DIV     32
`define RCST_OPT_MRC      2'h0
`define RCST_OPT_LP       2'h1
`define RCST_OPT_EXT      2'h2
`define RCST_RESP_OKAY    2'h0
`define RCST_RESP_SLVERR  2'h2
`endif

// file: rtl/rcst_pkg.sv
package rcst_pkg;
   typedef enum logic [3:0] {
      ST_BOOT, ST_MRC, ST_TO_LP, ST_LP_ARM, ST_LP, ST_TO_MRC, ST_MRC_FLAG, ST_MRC_ARM, ST_EXT
   } rcst_state_type;
   typedef struct packed {
      logic main_en;
      logic lp_en;
   } rcst_osc_en_type;
   typedef struct packed {
      logic [1:0] startup_opt;
      logic       icc_mode;
      logic       halt_wake;
   } rcst_mode_in_type;
endpackage

// file: rtl/rcst_top.sv
`timescale 1ns/1ns
`include "rcst_consts.svh"
// Functional notes
// - Reset reloads high trim with FFh
// - Ten-bit trim: high register plus bits 6:5
// - Lower trim code means higher frequency
// - Four factory trim bytes always readable
// - Startup option picks post-reset clock source
// - In-circuit mode forces main RC clock
// - Select set: LP on, flag cleared, hold 1
// - LP ready after 3 LP cycles, switch
// - Main RC stops after switch to LP
// - Select cleared: main on, count 8 cycles
// - Clear LP flag, set main flag, switch
// - LP oscillator stops after switch to main
// - Main RC off only in the LP and external clock states
// - Halt wake-up turns LP on under main
// - External clock keeps LP oscillator running
// - Bit 1 enables clock output pin
// - Bit 0 selects divide by 32
// - Switch register resets to 09h
// - Ready flags written by hardware only
module rcst_top #(
   parameter logic [7:0] FT_HI_5V = 8'h80,
   parameter logic [7:0] FT_LO_5V = 8'h00,
   parameter logic [7:0] FT_HI_3V = 8'h80,
   parameter logic [7:0] FT_LO_3V = 8'h00
) (
   // Clock and reset.
   input  wire logic                      CLK_SYS,
   input  wire logic                      RST_N,
   // Register bus, AXI4-Lite slave.
   input  wire logic [17:0]               S_AXI_AWADDR,
   input  wire logic                      S_AXI_AWVALID,
   output logic                           S_AXI_AWREADY,
   input  wire logic [31:0]               S_AXI_WDATA,
   input  wire logic [3:0]                S_AXI_WSTRB,
   input  wire logic                      S_AXI_WVALID,
   output logic                           S_AXI_WREADY,
   output logic [1:0]                     S_AXI_BRESP,
   output logic                           S_AXI_BVALID,
   input  wire logic                      S_AXI_BREADY,
   input  wire logic [17:0]               S_AXI_ARADDR,
   input  wire logic                      S_AXI_ARVALID,
   output logic                           S_AXI_ARREADY,
   output logic [31:0]                    S_AXI_RDATA,
   output logic [1:0]                     S_AXI_RRESP,
   output logic                           S_AXI_RVALID,
   input  wire logic                      S_AXI_RREADY,
   // Oscillator levels and mode straps.
   input  wire logic                      MAIN_RC_CLK,
   input  wire logic                      LP_RC_CLK,
   input  wire logic                      EXT_CLK,
   input  wire rcst_pkg::rcst_mode_in_type MODE,
   // Oscillator control and clock outputs.
   output rcst_pkg::rcst_osc_en_type      OSC_EN,
   output logic [9:0]                     TRIM_CODE,
   output logic                           SYS_CLK_OUT,
   output logic                           CPU_CLK,
   output logic                           CLK_OUT_PIN_O,
   output logic                           CLK_OUT_PIN_OE
);
   import rcst_pkg::*;

   localparam int SRC_MRC = 0;
   localparam int SRC_LP  = 1;
   localparam int SRC_EXT = 2;
   localparam logic [3:0] DIV_LAST = 4'(`RCST_SLOW_DIV / 2 - 1);
   localparam logic [7:0] CKSW_RESET = `RCST_RST_CKSW;

   rcst_state_type  state_r;
   rcst_osc_en_type osc_en_r;
   logic [2:0] src_in;
   logic [2:0] src_s1_r;
   logic [2:0] src_s2_r;
   logic [2:0] src_s3_r;
   logic [2:0] src_rise;
   logic [3:0] cnt_r;
   logic       sw_clk_r;
   logic       mrc_flag_r;
   logic       lp_flag_r;
   logic       src_sel_r;
   logic [7:0] mcc_r;
   logic [7:0] trim_hi_r;
   logic [1:0] trim_lo_r;
   logic       sw_prev_r;
   logic [3:0] div_cnt_r;
   logic       div_clk_r;
   logic       cpu_clk_r;
   logic       pin_o_r;
   logic       pin_oe_r;
   logic        awready_r;
   logic        wready_r;
   logic        bvalid_r;
   logic [1:0]  bresp_r;
   logic [17:0] aw_addr_r;
   logic [7:0]  wdata_r;
   logic        wstrb0_r;
   logic        arready_r;
   logic        rvalid_r;
   logic [1:0]  rresp_r;
   logic [7:0]  rdata_r;
   logic        wr_fire;
   logic        wr_hit;
   logic        in_circuit_comm_mode;

   assign in_circuit_comm_mode    = MODE.icc_mode;
   assign src_in = {EXT_CLK, LP_RC_CLK, MAIN_RC_CLK};

   // Each oscillator level is brought in by two flops; the third only serves the edge detector.
   for (genvar i = 0; i < 3; i++) begin : g_src
      always_ff @(posedge CLK_SYS or negedge RST_N) begin
         if (!RST_N) begin
            src_s1_r[i] <= 1'b0;
            src_s2_r[i] <= 1'b0;
            src_s3_r[i] <= 1'b0;
         end else begin
            src_s1_r[i] <= src_in[i];
            src_s2_r[i] <= src_s1_r[i];
            src_s3_r[i] <= src_s2_r[i];
         end
      end
      assign src_rise[i] = src_s2_r[i] & ~src_s3_r[i];
   end

   // Clock changeover sequencer. The output is only frozen while high and only released on a rising
   // edge of the new source, so neither direction can produce a short pulse.
   always_ff @(posedge CLK_SYS or negedge RST_N) begin
      if (!RST_N) begin
         state_r    <= ST_BOOT;
         cnt_r      <= 4'h0;
         sw_clk_r   <= 1'b1;
         mrc_flag_r <= 1'b0;
         lp_flag_r  <= 1'b1;
      end else begin
         case (state_r)
            ST_BOOT: begin
               cnt_r <= 4'h0;
               if (in_circuit_comm_mode || (MODE.startup_opt != `RCST_OPT_LP && MODE.startup_opt != `RCST_OPT_EXT)) begin
                  state_r    <= ST_MRC;
                  mrc_flag_r <= 1'b1;
                  lp_flag_r  <= 1'b0;
               end else if (MODE.startup_opt == `RCST_OPT_EXT) begin
                  state_r   <= ST_EXT;
                  lp_flag_r <= 1'b0;
               end else begin
                  state_r <= ST_LP;
               end
            end
            ST_MRC: begin
               sw_clk_r <= src_s2_r[SRC_MRC];
               if (src_sel_r && !in_circuit_comm_mode && src_s2_r[SRC_MRC]) begin
                  state_r    <= ST_TO_LP;
                  mrc_flag_r <= 1'b0;
                  cnt_r      <= 4'h0;
               end
            end
            ST_TO_LP: begin
               if (src_rise[SRC_LP]) begin
                  cnt_r <= cnt_r + 4'h1;
                  if (cnt_r == `RCST_LP_READY_CYC - 4'h1) begin
                     lp_flag_r <= 1'b1;
                     state_r   <= ST_LP_ARM;
                  end
               end
            end
            ST_LP_ARM: begin
               if (src_rise[SRC_LP]) begin
                  state_r <= ST_LP;
               end
            end
            ST_LP: begin
               sw_clk_r <= src_s2_r[SRC_LP];
               if (!src_sel_r || in_circuit_comm_mode) begin
                  state_r <= ST_TO_MRC;
                  cnt_r   <= 4'h0;
               end
            end
            ST_TO_MRC: begin
               sw_clk_r <= src_s2_r[SRC_LP];
               if (src_rise[SRC_MRC]) begin
                  cnt_r <= cnt_r + 4'h1;
                  if (cnt_r == `RCST_MRC_WAIT_CYC - 4'h1) begin
                     state_r <= ST_MRC_FLAG;
                     cnt_r   <= 4'h0;
                  end
               end
            end
            ST_MRC_FLAG: begin
               if (lp_flag_r) begin
                  sw_clk_r <= src_s2_r[SRC_LP];
                  if (src_rise[SRC_LP]) begin
                     lp_flag_r <= 1'b0;
                  end
               end else if (src_rise[SRC_MRC]) begin
                  cnt_r <= cnt_r + 4'h1;
                  if (cnt_r == `RCST_MRC_FLAG_CYC - 4'h1) begin
                     mrc_flag_r <= 1'b1;
                     state_r    <= ST_MRC_ARM;
                  end
               end
            end
            ST_MRC_ARM: begin
               if (src_rise[SRC_MRC]) begin
                  state_r <= ST_MRC;
               end
            end
            ST_EXT: begin
               sw_clk_r <= src_s2_r[SRC_EXT];
            end
            default: begin
               state_r <= ST_BOOT;
            end
         endcase
      end
   end

   // Oscillator enables follow the sequencer one cycle later.
   always_ff @(posedge CLK_SYS or negedge RST_N) begin
      if (!RST_N) begin
         osc_en_r <= '{main_en: 1'b1, lp_en: 1'b1};
      end else begin
         case (state_r)
            ST_MRC:  osc_en_r <= '{main_en: 1'b1, lp_en: MODE.halt_wake};
            ST_LP:   osc_en_r <= '{main_en: 1'b0, lp_en: 1'b1};
            ST_EXT:  osc_en_r <= '{main_en: 1'b0, lp_en: 1'b1};
            default: osc_en_r <= '{main_en: 1'b1, lp_en: 1'b1};
         endcase
      end
   end

   // Slow mode divider and clock output pin.
   always_ff @(posedge CLK_SYS or negedge RST_N) begin
      if (!RST_N) begin
         sw_prev_r <= 1'b1;
         div_cnt_r <= 4'h0;
         div_clk_r <= 1'b0;
         cpu_clk_r <= 1'b1;
         pin_o_r   <= 1'b0;
         pin_oe_r  <= 1'b0;
      end else begin
         sw_prev_r <= sw_clk_r;
         if (sw_clk_r && !sw_prev_r) begin
            if (div_cnt_r == DIV_LAST) begin
               div_cnt_r <= 4'h0;
               div_clk_r <= ~div_clk_r;
            end else begin
               div_cnt_r <= div_cnt_r + 4'h1;
            end
         end
         cpu_clk_r <= mcc_r[`RCST_MCC_SMS] ? div_clk_r : sw_clk_r;
         pin_oe_r  <= mcc_r[`RCST_MCC_MCO];
         pin_o_r   <= mcc_r[`RCST_MCC_MCO] & (mcc_r[`RCST_MCC_SMS] ? div_clk_r : sw_clk_r);
      end
   end

   // AXI4-Lite write channels; address and data are taken in either order.
   assign wr_fire = !awready_r && !wready_r && !bvalid_r;
   assign wr_hit  = (aw_addr_r[1:0] == 2'h0) &&
                    (aw_addr_r[17:2] == `RCST_IDX_MCC || aw_addr_r[17:2] == `RCST_IDX_TRIM_HI ||
                     aw_addr_r[17:2] == `RCST_IDX_INTEGRITY_CTRL_STATUS || aw_addr_r[17:2] == `RCST_IDX_CKSW);

   always_ff @(posedge CLK_SYS or negedge RST_N) begin
      if (!RST_N) begin
         awready_r <= 1'b1;
         aw_addr_r <= 18'h0;
         wready_r  <= 1'b1;
         wdata_r   <= 8'h0;
         wstrb0_r  <= 1'b0;
      end else begin
         if (S_AXI_AWVALID && awready_r) begin
            awready_r <= 1'b0;
            aw_addr_r <= S_AXI_AWADDR;
         end else if (bvalid_r && S_AXI_BREADY) begin
            awready_r <= 1'b1;
         end
         if (S_AXI_WVALID && wready_r) begin
            wready_r <= 1'b0;
            wdata_r  <= S_AXI_WDATA[7:0];
            wstrb0_r <= S_AXI_WSTRB[0];
         end else if (bvalid_r && S_AXI_BREADY) begin
            wready_r <= 1'b1;
         end
      end
   end

   always_ff @(posedge CLK_SYS or negedge RST_N) begin
      if (!RST_N) begin
         bvalid_r <= 1'b0;
         bresp_r  <= `RCST_RESP_OKAY;
      end else if (wr_fire) begin
         bvalid_r <= 1'b1;
         bresp_r  <= wr_hit ? `RCST_RESP_OKAY : `RCST_RESP_SLVERR;
      end else if (bvalid_r && S_AXI_BREADY) begin
         bvalid_r <= 1'b0;
      end
   end

   // Software registers; the ready flags have no write path.
   always_ff @(posedge CLK_SYS or negedge RST_N) begin
      if (!RST_N) begin
         mcc_r     <= `RCST_RST_MCC;
         trim_hi_r <= `RCST_RST_TRIM_HI;
         trim_lo_r <= `RCST_RST_TRIM_LO;
         src_sel_r <= CKSW_RESET[`RCST_CKSW_SEL];
      end else begin
         if (state_r == ST_BOOT) begin
            src_sel_r <= !in_circuit_comm_mode && (MODE.startup_opt == `RCST_OPT_LP);
         end else if (wr_fire && wr_hit && wstrb0_r) begin
            case (aw_addr_r[17:2])
               `RCST_IDX_MCC:     mcc_r <= {6'h0, wdata_r[`RCST_MCC_MCO], wdata_r[`RCST_MCC_SMS]};
               `RCST_IDX_TRIM_HI: trim_hi_r <= wdata_r;
               `RCST_IDX_INTEGRITY_CTRL_STATUS:   trim_lo_r <= wdata_r[`RCST_INTEGRITY_CTRL_STATUS_TLO_HI:`RCST_INTEGRITY_CTRL_STATUS_TLO_LO];
               `RCST_IDX_CKSW:    src_sel_r <= wdata_r[`RCST_CKSW_SEL];
               default:           mcc_r <= mcc_r;
            endcase
         end
      end
   end

   // AXI4-Lite read channel.
   always_ff @(posedge CLK_SYS or negedge RST_N) begin
      if (!RST_N) begin
         arready_r <= 1'b1;
         rvalid_r  <= 1'b0;
         rresp_r   <= `RCST_RESP_OKAY;
         rdata_r   <= 8'h0;
      end else if (S_AXI_ARVALID && arready_r) begin
         arready_r <= 1'b0;
         rvalid_r  <= 1'b1;
         rresp_r   <= `RCST_RESP_OKAY;
         rdata_r   <= 8'h0;
         if (S_AXI_ARADDR[1:0] != 2'h0) begin
            rresp_r <= `RCST_RESP_SLVERR;
         end else begin
            case (S_AXI_ARADDR[17:2])
               `RCST_IDX_MCC:      rdata_r <= mcc_r;
               `RCST_IDX_TRIM_HI:  rdata_r <= trim_hi_r;
               `RCST_IDX_INTEGRITY_CTRL_STATUS:    rdata_r <= {1'b0, trim_lo_r, 5'h0};
               `RCST_IDX_CKSW:     rdata_r <= {4'h0, lp_flag_r, mrc_flag_r, 1'b0, src_sel_r};
               `RCST_IDX_FT_HI_5V: rdata_r <= FT_HI_5V;
               `RCST_IDX_FT_LO_5V: rdata_r <= FT_LO_5V;
               `RCST_IDX_FT_HI_3V: rdata_r <= FT_HI_3V;
               `RCST_IDX_FT_LO_3V: rdata_r <= FT_LO_3V;
               default:            rresp_r <= `RCST_RESP_SLVERR;
            endcase
         end
      end else if (rvalid_r && S_AXI_RREADY) begin
         arready_r <= 1'b1;
         rvalid_r  <= 1'b0;
      end
   end

   assign S_AXI_AWREADY  = awready_r;
   assign S_AXI_WREADY   = wready_r;
   assign S_AXI_BVALID   = bvalid_r;
   assign S_AXI_BRESP    = bresp_r;
   assign S_AXI_ARREADY  = arready_r;
   assign S_AXI_RVALID   = rvalid_r;
   assign S_AXI_RRESP    = rresp_r;
   assign S_AXI_RDATA    = {24'h0, rdata_r};
   assign OSC_EN         = osc_en_r;
   assign TRIM_CODE      = {trim_hi_r, trim_lo_r};
   assign SYS_CLK_OUT    = sw_clk_r;
   assign CPU_CLK        = cpu_clk_r;
   assign CLK_OUT_PIN_O  = pin_o_r;
   assign CLK_OUT_PIN_OE = pin_oe_r;

   a_trim_reset: assert property (@(posedge CLK_SYS) $rose(RST_N) |-> TRIM_CODE == 10'h3fc)
      else $error("trim not restored after reset");
   a_trim_write: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
      wr_fire && wr_hit && wstrb0_r && aw_addr_r[17:2] == `RCST_IDX_TRIM_HI && state_r != ST_BOOT
      |=> TRIM_CODE[9:2] == $past(wdata_r))
      else $error("trim high write lost");
   a_icc_main: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
      state_r == ST_BOOT && in_circuit_comm_mode |=> state_r == ST_MRC ##1 OSC_EN.main_en)
      else $error("in-circuit mode did not force main clock");
   a_lp_request: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
      state_r == ST_MRC && src_sel_r && !in_circuit_comm_mode && src_s2_r[SRC_MRC]
      |=> !mrc_flag_r && SYS_CLK_OUT ##1 OSC_EN.lp_en)
      else $error("request to low-power clock mishandled");
   a_hold_high: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
      state_r inside {ST_TO_LP, ST_LP_ARM, ST_MRC_ARM} |-> SYS_CLK_OUT)
      else $error("clock not held high during changeover");
   a_lp_ready: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
      $rose(lp_flag_r) && $past(state_r) == ST_TO_LP |-> $past(cnt_r) == 4'h2 && state_r == ST_LP_ARM)
      else $error("low-power ready set at wrong count");
   a_main_stop: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
      state_r == ST_LP ##1 state_r == ST_LP |-> !OSC_EN.main_en)
      else $error("main oscillator left running on low-power clock");
   a_main_wait: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
      state_r == ST_TO_MRC ##1 state_r == ST_MRC_FLAG |-> $past(cnt_r) == 4'h7 && $past(src_rise[SRC_MRC]))
      else $error("main wait not eight cycles");
   a_flag_order: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
      $rose(mrc_flag_r) && state_r == ST_MRC_ARM |-> !lp_flag_r)
      else $error("main ready set before low-power ready cleared");
   a_lp_stop: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
      state_r == ST_MRC && !MODE.halt_wake |=> !OSC_EN.lp_en)
      else $error("low-power oscillator left running on main clock");
   a_ext_lp_on: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
      state_r == ST_EXT |=> OSC_EN.lp_en && !OSC_EN.main_en)
      else $error("low-power oscillator off with external clock");
   a_pin_enable: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
      !mcc_r[`RCST_MCC_MCO] |=> !CLK_OUT_PIN_OE && !CLK_OUT_PIN_O)
      else $error("clock pin driven while disabled");
   a_slow_div: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
      $changed(div_clk_r) |-> $past(div_cnt_r) == DIV_LAST)
      else $error("slow divider toggled early");
   a_switch_reset: assert property (@(posedge CLK_SYS) $rose(RST_N) |-> src_sel_r && lp_flag_r && !mrc_flag_r)
      else $error("switch register reset value wrong");

   c_to_lp:   cover property (@(posedge CLK_SYS) disable iff (!RST_N) state_r == ST_LP_ARM ##1 state_r == ST_LP);
   c_to_main: cover property (@(posedge CLK_SYS) disable iff (!RST_N) state_r == ST_MRC_ARM ##1 state_r == ST_MRC);
   c_slow:    cover property (@(posedge CLK_SYS) disable iff (!RST_N) mcc_r[`RCST_MCC_SMS] && $changed(div_clk_r));
   c_ext:     cover property (@(posedge CLK_SYS) disable iff (!RST_N) state_r == ST_EXT);

endmodule // rcst_top

// file: test/rcst_osc_model.sv
`timescale 1ns/1ns
module rcst_osc_model #(
   // Half periods are multiples of 10 ns, so every level change lands on a falling edge of the system clock.
   parameter int MAIN_HALF = 40,
   parameter int LP_HALF   = 110,
   parameter int EXT_HALF  = 70
) (
   // Enables from the block.
   input  wire rcst_pkg::rcst_osc_en_type osc_en,
   // Oscillator levels.
   output logic                           main_clk,
   output logic                           lp_clk,
   output logic                           ext_clk
);
   import rcst_pkg::*;
   initial begin
      main_clk = 1'b0;
      lp_clk = 1'b0;
      ext_clk = 1'b0;
   end
   always #(MAIN_HALF) main_clk = osc_en.main_en & ~main_clk;
   always #(LP_HALF) lp_clk = osc_en.lp_en & ~lp_clk;
   // The external source runs free.
   always #(EXT_HALF) ext_clk = ~ext_clk;
endmodule // rcst_osc_model

// file: test/rcst_top_test.sv
`timescale 1ns/1ns
`include "rcst_consts.svh"
module rcst_top_test;
   import rcst_pkg::*;
   localparam logic [7:0] FT_HI = 8'h5a;
   localparam logic [7:0] FT_LO = 8'h03;
   logic             clk_sys, rst_n, awvalid, wvalid, bready, arvalid, rready;
   logic             awready, wready, bvalid, arready, rvalid, main_clk, lp_clk, ext_clk;
   logic             sys_clk, cpu_clk, pin_o, pin_oe;
   logic [17:0]      awaddr, araddr;
   logic [31:0]      wdata, rdata;
   logic [1:0]       bresp, rresp;
   logic [9:0]       trim_code;
   rcst_mode_in_type mode;
   rcst_osc_en_type  osc_en;
   logic [33:0]      rq[$];
   logic [1:0]       bq[$];
   int               num_errors = 0;
   int               check_count = 0;
   int               seed = 32'hdf96;

   rcst_top #(.FT_HI_5V(FT_HI), .FT_LO_3V(FT_LO)) uut (
      .CLK_SYS(clk_sys), .RST_N(rst_n), .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready),
      .S_AXI_WDATA(wdata), .S_AXI_WSTRB(4'hf), .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp),
      .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid),
      .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready),
      .MAIN_RC_CLK(main_clk), .LP_RC_CLK(lp_clk), .EXT_CLK(ext_clk), .MODE(mode), .OSC_EN(osc_en),
      .TRIM_CODE(trim_code), .SYS_CLK_OUT(sys_clk), .CPU_CLK(cpu_clk), .CLK_OUT_PIN_O(pin_o), .CLK_OUT_PIN_OE(pin_oe));

   rcst_osc_model osc (.osc_en(osc_en), .main_clk(main_clk), .lp_clk(lp_clk), .ext_clk(ext_clk));

   initial begin
      clk_sys = 1'b0;
      forever #5 clk_sys = ~clk_sys;
   end

   task automatic check(input logic [33:0] got, input logic [33:0] exp);
      check_count++;
      if (got !== exp) begin
         num_errors++;
         $display("MISMATCH at %0t got %h exp %h", $time, got, exp);
      end
   endtask

   task automatic tmo(input int n);
      if (n >= 3000) begin
         num_errors++;
         $display("MISMATCH at %0t wait timed out got %h exp %h", $time, n, 3000);
         test_done();
      end
   endtask

   task automatic test_done();
      $display("comparisons %0d mismatches %0d", check_count, num_errors);
      if (num_errors == 0 && check_count > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask

   task automatic wr(input logic [15:0] idx, input logic [7:0] d, input logic [1:0] er = 2'h0);
      int   n;
      logic aw_p, w_p;
      bq.push_back(er);
      @(posedge clk_sys);
      awaddr <= {idx, 2'b00};
      wdata <= {24'($random(seed)), d};
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      aw_p = 1'b1;
      w_p = 1'b1;
      n = 0;
      while ((aw_p || w_p) && n < 3000) begin
         @(posedge clk_sys);
         n++;
         if (aw_p && awready === 1'b1) begin
            awvalid <= 1'b0;
            aw_p = 1'b0;
         end
         if (w_p && wready === 1'b1) begin
            wvalid <= 1'b0;
            w_p = 1'b0;
         end
      end
      do begin
         @(posedge clk_sys);
         n++;
      end while (bvalid !== 1'b1 && n < 3000);
      bready <= 1'b0;
      tmo(n);
   endtask

   task automatic rd(input logic [15:0] idx, input logic [7:0] d, input logic [1:0] er = 2'h0);
      int n;
      rq.push_back({er, 24'h0, d});
      @(posedge clk_sys);
      araddr <= {idx, 2'b00};
      arvalid <= 1'b1;
      rready <= 1'b1;
      n = 0;
      do begin
         @(posedge clk_sys);
         n++;
      end while (arready !== 1'b1 && n < 3000);
      arvalid <= 1'b0;
      while (rvalid !== 1'b1 && n < 3000) begin
         @(posedge clk_sys);
         n++;
      end
      rready <= 1'b0;
      tmo(n);
   endtask

   task automatic wait_en(input logic [1:0] v);
      int n;
      n = 0;
      while (osc_en !== v && n < 3000) begin
         @(posedge clk_sys);
         n++;
      end
      tmo(n);
      check(34'(osc_en), 34'(v));
   endtask

   task automatic do_reset(input logic [1:0] opt, input logic in_circuit_comm_mode);
      @(posedge clk_sys);
      rst_n <= 1'b0;
      mode <= {opt, in_circuit_comm_mode, 1'b0};
      repeat (10) @(posedge clk_sys);
      rst_n <= 1'b1;
      repeat (3) @(posedge clk_sys);
   endtask

   // Bus answers are taken off the queues in the order they were requested.
   always @(posedge clk_sys) begin
      if (bvalid === 1'b1 && bready === 1'b1) check({32'h0, bresp}, {32'h0, bq.pop_front()});
      if (rvalid === 1'b1 && rready === 1'b1) check({rresp, rdata}, rq.pop_front());
   end

   initial begin
      logic [7:0] t;
      logic [1:0] s;
      int         n, k, c;
      logic       ps, pc;
      rst_n <= 1'b0;
      {awvalid, wvalid, bready, arvalid, rready} <= 5'h0;
      awaddr <= 18'h0;
      araddr <= 18'h0;
      wdata <= 32'h0;
      mode <= 4'h0;
      do_reset(`RCST_OPT_LP, 1'b0);
      rd(`RCST_IDX_CKSW, `RCST_RST_CKSW);
      rd(`RCST_IDX_MCC, `RCST_RST_MCC);
      rd(`RCST_IDX_TRIM_HI, `RCST_RST_TRIM_HI);
      check(34'(trim_code), 34'h3fc);
      check(34'(osc_en), 34'h1);
      wr(`RCST_IDX_TRIM_HI, 8'h80);
      check(34'(trim_code), 34'h200);
      t = 8'($random(seed));
      s = 2'($random(seed));
      wr(`RCST_IDX_TRIM_HI, t);
      wr(`RCST_IDX_INTEGRITY_CTRL_STATUS, {1'b0, s, 5'h0});
      rd(`RCST_IDX_TRIM_HI, t);
      check(34'(trim_code), 34'({t, s}));
      $display("test startup and trim done");
      wr(`RCST_IDX_CKSW, 8'h00);
      wait_en(2'b10);
      rd(`RCST_IDX_CKSW, 8'h04);
      wr(`RCST_IDX_CKSW, 8'h0c);
      rd(`RCST_IDX_CKSW, 8'h04);
      mode.halt_wake <= 1'b1;
      repeat (6) @(posedge clk_sys);
      check(34'(osc_en), 34'h3);
      mode.halt_wake <= 1'b0;
      wait_en(2'b10);
      wr(`RCST_IDX_CKSW, 8'h01);
      wait_en(2'b01);
      rd(`RCST_IDX_CKSW, 8'h09);
      $display("test clock switching done");
      wr(`RCST_IDX_MCC, 8'hff);
      rd(`RCST_IDX_MCC, 8'h03);
      check(34'(pin_oe), 34'h1);
      n = 0;
      k = 0;
      c = 0;
      ps = sys_clk;
      pc = cpu_clk;
      while (c < 2 && n < 3000) begin
         @(posedge clk_sys);
         n++;
         if (sys_clk === 1'b1 && ps === 1'b0) k++;
         if (cpu_clk === 1'b1 && pc === 1'b0) begin
            c++;
            if (c == 1) k = 0;
         end
         ps = sys_clk;
         pc = cpu_clk;
      end
      tmo(n);
      check(34'(k), 34'(`RCST_SLOW_DIV));
      check(34'(pin_o), 34'(cpu_clk));
      $display("test main clock control done");
      do_reset(`RCST_OPT_LP, 1'b1);
      rd(`RCST_IDX_CKSW, 8'h04);
      rd(`RCST_IDX_TRIM_HI, 8'hff);
      check(34'(pin_oe), 34'h0);
      check(34'(pin_o), 34'h0);
      wr(`RCST_IDX_TRIM_HI, t);
      check(34'(trim_code), 34'({t, 2'h0}));
      do_reset(`RCST_OPT_MRC, 1'b0);
      rd(`RCST_IDX_CKSW, 8'h04);
      wait_en(2'b10);
      do_reset(`RCST_OPT_EXT, 1'b0);
      rd(`RCST_IDX_CKSW, 8'h00);
      wait_en(2'b01);
      rd(16'h0040, 8'h00, `RCST_RESP_SLVERR);
      rd(`RCST_IDX_FT_HI_5V, FT_HI);
      rd(`RCST_IDX_FT_LO_3V, FT_LO);
      wr(`RCST_IDX_FT_HI_5V, 8'h55, `RCST_RESP_SLVERR);
      rd(`RCST_IDX_FT_HI_5V, FT_HI);
      $display("test resets and factory bytes done");
      test_done();
   end
endmodule // rcst_top_test
